// file: rtl/wake_ctrl_consts.vh
// Register offsets, field positions, reset values and timing counts of the wakeup controller
`ifndef WAKE_CTRL_CONSTS_VH
`define WAKE_CTRL_CONSTS_VH

`define OFS_SUPPLY_CTRL       8'h00
`define OFS_SMON_MODE         8'h04
`define OFS_MODE              8'h08
`define OFS_WAKE_MODE         8'h0C
`define OFS_WAKE_INPUTS       8'h10
`define OFS_STATUS            8'h14
`define OFS_WRITE_PROTECT     8'hE4
`define OFS_STIMULUS          8'hF0

`define MODE_RESET            32'h0000DA00

`define WM_FORCE_EN           0
`define WM_SMON_EN            1
`define WM_RTT_EN             2
`define WM_RTC_EN             3
`define WM_LP_EN_A            5
`define WM_LP_EN_B            6
`define WM_CLR_EN             7
`define WM_FDBC_LO            8
`define WM_WDBC_LO            12
`define WM_LPCNT_LO           16
`define WM_CLR_B_DIS          20

`define ST_FORCE              1
`define ST_LP_A               16
`define ST_LP_B               17
`define ST_WAKE_LO            16

`define CTRL_VROFF            2
`define CTRL_KEY              8'hA5

`define DBC_3                 16'd3
`define DBC_32                16'd32
`define DBC_512               16'd512
`define DBC_4096              16'd4096
`define DBC_32768             16'd32768

`endif

// file: rtl/backup_wakeup_debounce_ctrl.v
// Backup-domain wakeup controller with debouncers, status and write protection
`include "wake_ctrl_consts.vh"
module backup_wakeup_debounce_ctrl #(
  parameter N_WAKE = 16
) (
  input  wire              mclk,
  input  wire              reset,
  input  wire [7:0]        s_axi_awaddr,
  input  wire              s_axi_awvalid,
  output reg               s_axi_awready,
  input  wire [31:0]       s_axi_wdata,
  input  wire [3:0]        s_axi_wstrb,
  input  wire              s_axi_wvalid,
  output reg               s_axi_wready,
  output reg  [1:0]        s_axi_bresp,
  output reg               s_axi_bvalid,
  input  wire              s_axi_bready,
  input  wire [7:0]        s_axi_araddr,
  input  wire              s_axi_arvalid,
  output reg               s_axi_arready,
  output reg  [31:0]       s_axi_rdata,
  output reg  [1:0]        s_axi_rresp,
  output reg               s_axi_rvalid,
  input  wire              s_axi_rready,
  input  wire              force_wake_pin,
  input  wire [N_WAKE-1:0] wake_input_n,
  input  wire              rtc_sampling_wave_pin,
  input  wire              rtc_alarm,
  input  wire              rtt_alarm,
  input  wire              supply_monitor_detect,
  output reg               core_supply_on,
  output reg               backup_clear
);

  reg [31:0] wake_mode_reg;
  reg [31:0] wake_inputs_reg;
  reg [31:0] smon_mode_reg;
  reg [31:0] mode_reg;
  reg [31:0] system_write_protect_mode;
  reg        force_wake_status;
  reg [N_WAKE-1:0] wake_input_source_flag_n;
  reg [1:0]  lowpower_debounce_flag_n;
  reg        aw_held;
  reg        w_held;
  reg [7:0]  aw_addr;
  reg [31:0] w_data;
  reg [3:0]  w_strb;
  reg        force_prev;
  reg [15:0] force_cnt;
  reg [15:0] wake_cnt;
  reg        wake_fired;
  reg        force_fired;
  reg        wave_prev;

  wire write_protect_enable = system_write_protect_mode[0];
  wire force_wake_enable = wake_mode_reg[`WM_FORCE_EN];
  wire [2:0] force_wake_debounce_sel = wake_mode_reg[`WM_FDBC_LO +: 3];
  wire [2:0] wake_input_debounce_sel = wake_mode_reg[`WM_WDBC_LO +: 3];
  wire [2:0] lowpower_sample_count = wake_mode_reg[`WM_LPCNT_LO +: 3];
  wire lowpower_debounce_enable_a = wake_mode_reg[`WM_LP_EN_A];
  wire lowpower_debounce_enable_b = wake_mode_reg[`WM_LP_EN_B];
  wire tamper_clear_enable = wake_mode_reg[`WM_CLR_EN];
  wire tamper_b_clear_disable = wake_mode_reg[`WM_CLR_B_DIS];
  wire [N_WAKE-1:0] wake_input_enable_n = wake_inputs_reg[N_WAKE-1:0];
  wire [N_WAKE-1:0] wake_input_polarity_n = wake_inputs_reg[16 +: N_WAKE];
  wire tamper_a_polarity = wake_input_polarity_n[0];
  wire tamper_b_polarity = wake_input_polarity_n[10];

  function [15:0] dbc_period;
    input [2:0] sel;
    begin
      case (sel)
        3'h1: dbc_period = `DBC_3;
        3'h2: dbc_period = `DBC_32;
        3'h3: dbc_period = `DBC_512;
        3'h4: dbc_period = `DBC_4096;
        3'h5: dbc_period = `DBC_32768;
        default: dbc_period = 16'h0001;
      endcase
    end
  endfunction

  // Polarity-adjusted, enabled inputs
  wire [N_WAKE-1:0] wake_active;
  genvar gi;
  generate
    for (gi = 0; gi < N_WAKE; gi = gi + 1) begin : g_wake
      assign wake_active[gi] = wake_input_enable_n[gi] &
                               (wake_input_n[gi] == wake_input_polarity_n[gi]);
    end
  endgenerate
  wire wake_any = |wake_active;

  // Force pin is active low; zero setting needs a seen fall then one low cycle
  wire force_low = force_wake_enable & ~force_wake_pin;
  wire [15:0] force_period = dbc_period(force_wake_debounce_sel);
  wire force_hit = force_low & ~force_fired &
                   ((force_wake_debounce_sel == 3'h0) ? (force_cnt != 16'h0000)
                                                      : (force_cnt >= force_period));
  wire [15:0] wake_period = dbc_period(wake_input_debounce_sel);
  wire wake_hit = wake_any & ~wake_fired &
                  ((wake_input_debounce_sel == 3'h0) ? 1'b1
                                                     : (wake_cnt >= wake_period));

  // Low-power debouncers sample on the falling edge of the sampling wave
  wire sample_edge = wave_prev & ~rtc_sampling_wave_pin;
  wire [2:0] lp_need = (lowpower_sample_count < 3'h2) ? 3'h2 : lowpower_sample_count;
  wire [1:0] lp_enable = {lowpower_debounce_enable_b, lowpower_debounce_enable_a};
  wire [1:0] lp_pin = {wake_input_n[10], wake_input_n[0]};
  wire [1:0] lp_pol = {tamper_b_polarity, tamper_a_polarity};
  wire [1:0] lp_hit;
  genvar li;
  generate
    for (li = 0; li < 2; li = li + 1) begin : g_lp
      // One count per tamper input; the needed count is shared
      reg  [2:0] lp_cnt;
      reg        lp_fire;
      wire       lp_act = lp_enable[li] & (lp_pin[li] == lp_pol[li]);
      // Widened sum so a saturated count cannot wrap past the target
      assign lp_hit[li] = sample_edge & lp_act & ~lp_fire &
                          (({1'b0, lp_cnt} + 4'h1) >= {1'b0, lp_need});
      always @(posedge mclk or posedge reset) begin
        if (reset) begin
          lp_cnt <= 3'h0;
          lp_fire <= 1'b0;
        end else if (sample_edge) begin
          if (~lp_act)
            lp_cnt <= 3'h0;
          else if (lp_cnt != 3'h7)
            lp_cnt <= lp_cnt + 3'h1;
          lp_fire <= lp_act & (lp_fire | lp_hit[li]);
        end
      end
    end
  endgenerate
  wire lp_hit_a = lp_hit[0];
  wire lp_hit_b = lp_hit[1];

  wire wake_event = force_hit | wake_hit | lp_hit_a | lp_hit_b |
                    (wake_mode_reg[`WM_RTC_EN] & rtc_alarm) |
                    (wake_mode_reg[`WM_RTT_EN] & rtt_alarm) |
                    (wake_mode_reg[`WM_SMON_EN] & supply_monitor_detect);

  // Bus handshake
  wire do_write = aw_held & w_held & ~s_axi_bvalid;
  wire do_read = s_axi_arvalid & s_axi_arready;
  wire status_read = do_read & (s_axi_araddr == `OFS_STATUS);
  wire [31:0] wmask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
  wire wr_ok = ~write_protect_enable;
  wire vroff_cmd = do_write & wr_ok & (aw_addr == `OFS_SUPPLY_CTRL) & w_strb[3] &
                   (w_data[31:24] == `CTRL_KEY) & w_data[`CTRL_VROFF];
  wire addr_known = (aw_addr == `OFS_SUPPLY_CTRL) | (aw_addr == `OFS_SMON_MODE) |
                    (aw_addr == `OFS_MODE) | (aw_addr == `OFS_WAKE_MODE) |
                    (aw_addr == `OFS_WAKE_INPUTS) | (aw_addr == `OFS_STATUS) |
                    (aw_addr == `OFS_WRITE_PROTECT);

  reg [31:0] next_rdata;
  reg        next_rerr;
  always @* begin
    next_rdata = 32'h00000000;
    next_rerr = 1'b0;
    case (s_axi_araddr)
      `OFS_SUPPLY_CTRL:   next_rdata = 32'h00000000;
      `OFS_SMON_MODE:     next_rdata = smon_mode_reg;
      `OFS_MODE:          next_rdata = mode_reg;
      `OFS_WAKE_MODE:     next_rdata = wake_mode_reg;
      `OFS_WAKE_INPUTS:   next_rdata = wake_inputs_reg;
      `OFS_STATUS: begin
        next_rdata[`ST_FORCE] = force_wake_status;
        next_rdata[`ST_LP_A - 3] = lowpower_debounce_flag_n[0];
        next_rdata[`ST_LP_B - 3] = lowpower_debounce_flag_n[1];
        next_rdata[`ST_WAKE_LO +: N_WAKE] = wake_input_source_flag_n;
        next_rdata[0] = core_supply_on;
      end
      `OFS_WRITE_PROTECT: next_rdata = system_write_protect_mode;
      default:            next_rerr = 1'b1;
    endcase
  end

  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
    end else begin
      s_axi_awready <= ~aw_held & ~s_axi_awready & s_axi_awvalid;
      s_axi_wready <= ~w_held & ~s_axi_wready & s_axi_wvalid;
      if (s_axi_awvalid & s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= addr_known ? 2'b00 : 2'b10;
      end else if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_held <= 1'b0;
        w_held <= 1'b0;
      end
    end
  end

  // Read channel answers one cycle after its address is taken
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= 2'b00;
      s_axi_rdata <= 32'h00000000;
    end else begin
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
      if (do_read) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= next_rdata;
        s_axi_rresp <= next_rerr ? 2'b10 : 2'b00;
      end else if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Register writes; protection covers neither the protect register nor the wake inputs register
  wire wr_smon = do_write & wr_ok & (aw_addr == `OFS_SMON_MODE);
  wire wr_mode = do_write & wr_ok & (aw_addr == `OFS_MODE);
  wire wr_wake_mode = do_write & wr_ok & (aw_addr == `OFS_WAKE_MODE);
  wire wr_wake_inputs = do_write & (aw_addr == `OFS_WAKE_INPUTS);
  wire wr_protect = do_write & (aw_addr == `OFS_WRITE_PROTECT);

  always @(posedge mclk or posedge reset) begin
    if (reset)
      smon_mode_reg <= 32'h00000000;
    else if (wr_smon)
      smon_mode_reg <= (smon_mode_reg & ~wmask) | (w_data & wmask);
  end

  always @(posedge mclk or posedge reset) begin
    if (reset)
      mode_reg <= `MODE_RESET;
    else if (wr_mode)
      mode_reg <= (mode_reg & ~wmask) | (w_data & wmask);
  end

  always @(posedge mclk or posedge reset) begin
    if (reset)
      wake_mode_reg <= 32'h00000000;
    else if (wr_wake_mode)
      wake_mode_reg <= (wake_mode_reg & ~wmask) | (w_data & wmask);
  end

  always @(posedge mclk or posedge reset) begin
    if (reset)
      wake_inputs_reg <= 32'h00000000;
    else if (wr_wake_inputs)
      wake_inputs_reg <= (wake_inputs_reg & ~wmask) | (w_data & wmask);
  end

  always @(posedge mclk or posedge reset) begin
    if (reset)
      system_write_protect_mode <= 32'h00000000;
    else if (wr_protect)
      system_write_protect_mode <= (system_write_protect_mode & ~wmask) | (w_data & wmask);
  end

  // Force pin debouncer
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      force_prev <= 1'b1;
      force_cnt <= 16'h0000;
      force_fired <= 1'b0;
    end else begin
      force_prev <= force_wake_pin;
      // Every setting counts only from a seen fall; count climbs while low, saturating at FFFF
      if (~force_low)
        force_cnt <= 16'h0000;
      else if ((force_prev | (force_cnt != 16'h0000)) & (force_cnt != 16'hFFFF))
        force_cnt <= force_cnt + 16'h0001;
      force_fired <= force_low & (force_fired | force_hit);
    end
  end

  // Shared wake input debouncer; one fire per held condition, release rearms
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      wake_cnt <= 16'h0000;
      wake_fired <= 1'b0;
    end else begin
      if (~wake_any)
        wake_cnt <= 16'h0000;
      else if (wake_cnt != 16'hFFFF)
        wake_cnt <= wake_cnt + 16'h0001;
      wake_fired <= wake_any & (wake_fired | wake_hit);
    end
  end

  // Sampling wave history; idle low so reset makes no false edge
  always @(posedge mclk or posedge reset) begin
    if (reset)
      wave_prev <= 1'b0;
    else
      wave_prev <= rtc_sampling_wave_pin;
  end

  // Core supply returns on any wakeup; key-gated command drops it
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      core_supply_on <= 1'b1;
      backup_clear <= 1'b0;
    end else begin
      if (wake_event)
        core_supply_on <= 1'b1;
      else if (vroff_cmd)
        core_supply_on <= 1'b0;
      // Registered clear costs one cycle; scratch clear is a strobe
      backup_clear <= tamper_clear_enable &
                      (lp_hit_a | (lp_hit_b & ~tamper_b_clear_disable));
    end
  end

  // Status flags; force flag set wins over read-clear, other flags change only on a new hit
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      force_wake_status <= 1'b0;
      wake_input_source_flag_n <= {N_WAKE{1'b0}};
      lowpower_debounce_flag_n <= 2'b00;
    end else begin
      if (force_hit)
        force_wake_status <= 1'b1;
      else if (status_read)
        force_wake_status <= 1'b0;
      if (wake_hit)
        wake_input_source_flag_n <= wake_active;
      if (lp_hit_a | lp_hit_b)
        lowpower_debounce_flag_n <= {lp_hit_b, lp_hit_a};
    end
  end

endmodule

// file: bench/wake_ctrl_props.sv
// Port-level property checker for the backup wakeup controller
module wake_ctrl_props #(
  parameter N_WAKE = 16
) (
  input wire logic              mclk,
  input wire logic              reset,
  input wire logic [7:0]        s_axi_awaddr,
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic [31:0]       s_axi_wdata,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic              force_wake_pin,
  input wire logic [N_WAKE-1:0] wake_input_n,
  input wire logic              rtc_alarm,
  input wire logic              rtt_alarm,
  input wire logic              supply_monitor_detect,
  input wire logic              core_supply_on,
  input wire logic              backup_clear
);
  logic [7:0]  wa;
  logic [31:0] wm;
  logic [31:0] wir;
  logic        wp;
  // Address may be taken in the same cycle as the data
  wire [7:0] wad = s_axi_awready ? s_axi_awaddr : wa;
  wire       wr  = s_axi_wvalid && s_axi_wready;
  wire       hit = wr && wad == 8'h00 && s_axi_wdata[31:24] == 8'hA5 && s_axi_wdata[2];
  wire       act = |(~(wake_input_n[15:0] ^ wir[31:16]) & wir[15:0]);
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      wa  <= 8'h00;
      wm  <= 32'h0;
      wir <= 32'h0;
      wp  <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) wa <= s_axi_awaddr;
      if (wr && wad == 8'hE4) wp <= s_axi_wdata[0];
      if (wr && wad == 8'h0C && !wp) wm <= s_axi_wdata;
      if (wr && wad == 8'h10) wir <= s_axi_wdata;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  chk_input_wake: assert property (
    !core_supply_on && act && !$past(act) && wm[14:12] == 3'h0 |-> ##[1:4] core_supply_on)
    else $error("input wake missing");
  chk_force_wake: assert property (
    (!core_supply_on && wm[0] && wm[10:8] == 3'h1 && !force_wake_pin) [*5]
    |-> ##[0:3] core_supply_on) else $error("force wake missing");
  chk_rtc_wake: assert property (
    !core_supply_on && $rose(rtc_alarm) && wm[3] |-> ##[1:4] core_supply_on)
    else $error("rtc alarm wake missing");
  chk_rtt_wake: assert property (
    !core_supply_on && $rose(rtt_alarm) && wm[2] |-> ##[1:4] core_supply_on)
    else $error("rtt alarm wake missing");
  chk_monitor_wake: assert property (
    !core_supply_on && $rose(supply_monitor_detect) && wm[1] |-> ##[1:4] core_supply_on)
    else $error("monitor wake missing");
  chk_clear_single: assert property (backup_clear |=> !backup_clear)
    else $error("clear pulse too long");
  chk_clear_enabled: assert property (backup_clear |-> wm[7])
    else $error("clear while disabled");
  chk_ctrl_locked: assert property (
    hit && wp && core_supply_on |=> core_supply_on [*4]) else $error("locked command acted");
endmodule

bind backup_wakeup_debounce_ctrl wake_ctrl_props #(.N_WAKE(N_WAKE)) wake_ctrl_props_inst (
  .mclk(mclk), .reset(reset), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .force_wake_pin(force_wake_pin), .wake_input_n(wake_input_n),
  .rtc_alarm(rtc_alarm), .rtt_alarm(rtt_alarm), .supply_monitor_detect(supply_monitor_detect),
  .core_supply_on(core_supply_on), .backup_clear(backup_clear));

// file: bench/wake_pins_model.sv
// External pin model: force button, wake switches and sampling wave
module wake_pins_model (
  input  wire logic        mclk,
  input  wire logic        force_low,
  input  wire logic [15:0] wake_act,
  input  wire logic        run,
  output logic             force_wake_pin,
  output logic [15:0]      wake_input_n,
  output logic             rtc_sampling_wave_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] ph = 2'h0;
  // Pull-up holds the button line high while released
  assign force_wake_pin = !force_low;
  assign wake_input_n = wake_act;
  // Wave stands still low between bursts; falls once every four clocks
  always @(posedge mclk) ph <= run ? ph + 2'h1 : 2'h0;
  assign rtc_sampling_wave_pin = run && ph[1];
endmodule

// file: bench/backup_wakeup_debounce_ctrl_bench.sv
// Self-checking bench for the backup wakeup controller
module backup_wakeup_debounce_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk, reset, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, fpin, wave, force_low, run, core_supply_on, backup_clear;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp;
  logic [15:0] wins, wake_act;
  logic [2:0]  alarms;
  int err_total, total_checks, clears;
  backup_wakeup_debounce_ctrl #(.N_WAKE(16)) backup_wakeup_debounce_ctrl_inst (
    .mclk(mclk), .reset(reset), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .force_wake_pin(fpin),
    .wake_input_n(wins), .rtc_sampling_wave_pin(wave), .rtc_alarm(alarms[2]),
    .rtt_alarm(alarms[1]), .supply_monitor_detect(alarms[0]),
    .core_supply_on(core_supply_on), .backup_clear(backup_clear));
  wake_pins_model wake_pins_model_inst (.mclk(mclk), .force_low(force_low), .wake_act(wake_act),
    .run(run), .force_wake_pin(fpin), .wake_input_n(wins), .rtc_sampling_wave_pin(wave));
  initial begin
    mclk = 0;
    forever #25 mclk = ~mclk;
  end
  always @(negedge mclk) if (backup_clear === 1'b1) clears++;
  task end_of_test;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task bail;
    $display("BAD %0t wait expired", $time);
    err_total++;
    end_of_test;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %0t saw %h expected %h", $time, seen, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic ar, w, b;
    @(posedge mclk);
    awaddr <= a; awvalid <= 1; wdata <= d; wvalid <= 1; bready <= 1;
    for (int n = 0; n < 100; n++) begin
      @(negedge mclk);
      ar = awready; w = wready; b = bvalid;
      @(posedge mclk);
      if (ar) awvalid <= 0;
      if (w) wvalid <= 0;
      if (b) begin bready <= 0; return; end
    end
    bail;
  endtask
  task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar, v;
    @(posedge mclk);
    araddr <= a; arvalid <= 1; rready <= 1;
    for (int n = 0; n < 100; n++) begin
      @(negedge mclk);
      ar = arready; v = rvalid; d = rdata; r = rresp;
      @(posedge mclk);
      if (ar) arvalid <= 0;
      if (v) begin rready <= 0; return; end
    end
    bail;
  endtask
  task wait_core(input logic e, output int n);
    for (n = 0; n < 2000; n++) begin
      @(negedge mclk);
      if (core_supply_on === e) begin @(posedge mclk); return; end
    end
    bail;
  endtask
  task core_off;
    int n;
    // Callers idle enabled wake inputs before backup entry, except t_input's held input 3
    wr(8'h00, 32'hA500_0004);
    wait_core(0, n);
  endtask
  task t_protect;
    logic [31:0] d; logic [1:0] r;
    wr(8'hE4, 32'h0000_0001); wr(8'h0C, 32'h0000_000F);
    rd(8'h0C, d, r); chk(d, 32'h0);
    wr(8'h00, 32'hA500_0004); repeat (6) @(posedge mclk);
    chk(core_supply_on, 1);
    rd(8'h18, d, r); chk(r, 2'h2);
    wr(8'hE4, 32'h0);
  endtask
  task t_force;
    logic [31:0] d; logic [1:0] r; int n;
    wr(8'h0C, 32'h0); core_off; force_low <= 1;
    repeat (20) @(posedge mclk); chk(core_supply_on, 0);
    force_low <= 0; wr(8'h0C, 32'h0000_0101); force_low <= 1;
    wait_core(1, n); chk(n >= 3, 1);
    force_low <= 0;
    rd(8'h14, d, r); chk(d[1], 1);
    rd(8'h14, d, r); chk(d[1], 0);
    wr(8'h0C, 32'h0000_0001); core_off; force_low <= 1;
    wait_core(1, n); chk(core_supply_on, 1);
    force_low <= 0;
  endtask
  task t_input;
    logic [31:0] d; logic [1:0] r; int n;
    wr(8'h10, 32'h0008_0008); wr(8'h0C, 32'h0); core_off; wake_act[3] <= 1;
    wait_core(1, n); chk(core_supply_on, 1);
    rd(8'h14, d, r); chk(d[31:16], 16'h0008);
    core_off; repeat (20) @(posedge mclk); chk(core_supply_on, 0);
    wake_act[3] <= 0; @(posedge mclk); wake_act[3] <= 1;
    wait_core(1, n); chk(core_supply_on, 1);
    wake_act[3] <= 0;
    wr(8'h0C, 32'h0000_1000); core_off; wake_act[3] <= 1;
    wait_core(1, n); chk(n >= 3, 1);
    wake_act[3] <= 0;
  endtask
  // Wave stays still first, so nothing may be sampled before it runs
  task t_tamper(input int i, input logic [31:0] m, input logic [31:0] w, input int c, input int f);
    logic [31:0] d; logic [1:0] r; int n, c0;
    wr(8'h10, w); wr(8'h0C, m); core_off; c0 = clears; wake_act[i] <= 1;
    repeat (30) @(posedge mclk); chk(core_supply_on, 0);
    run <= 1; wait_core(1, n); repeat (3) @(posedge mclk);
    chk(clears - c0, c);
    run <= 0; wake_act[i] <= 0;
    rd(8'h14, d, r); chk(d[f], 1);
  endtask
  task t_alarms;
    int n;
    for (int i = 0; i < 3; i++) begin
      wr(8'h0C, 32'h0000_0002 << i); core_off; alarms <= 3'h1 << i;
      wait_core(1, n); chk(core_supply_on, 1);
      alarms <= 3'h0;
    end
  endtask
  initial begin
    reset = 1; awvalid = 0; wvalid = 0; bready = 0; arvalid = 0; rready = 0;
    awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0; force_low = 0; run = 0;
    wake_act = 16'h0; alarms = 3'h0;
    repeat (20) @(posedge mclk);
    reset <= 0;
    t_protect;
    t_force;
    t_input;
    t_tamper(0, 32'h0000_00A0, 32'h0001_0000, 1, 13);
    t_tamper(10, 32'h0013_00C0, 32'h0400_0000, 0, 14);
    t_alarms;
    end_of_test;
  end
endmodule
